// ==== pcu_pkg.sv ====
// Package: constants, types and register map for the code check and change unit
//
// Notes on behaviour
// R01: Comparing a code sets a security status valid on every logical channel.
// R02: Check compares only when the code is neither disabled nor blocked.
// R03: A code-guarded function needs a prior successful check unless code disabled.
// R04: Correct check reloads the remaining-attempts counter to three.
// R05: Wrong check decrements the shared counter, whatever channel carried it.
// R06: Third consecutive wrong check blocks the code, answer 63C0; kept across sessions. Here sys_rst reloads the counter to three and clears blocked.
// R07: Any later check on a blocked code answers 6983 with no comparison; the code answers an empty-data query with 63C0 instead.
// R08: A blocked code leaves dependent access conditions unfulfilled until unblocked.
// R09: Empty check data queries attempts; answer 63CX with X tries remaining.
// R10: Failed check of an unblocked code reports remaining tries in 63CX.
// R11: Terminal sends check with first byte 00, length empty or 08.
// R12: Reference byte: bit8 global/specific, bits7-6 zero, number 01-1F; zero unsupported.
// R13: Change compares old code and only on match replaces it, all channels.
// R14: Change acts only when neither disabled nor blocked; old and new supplied.
// R15: Change with matching old code reloads counter to three, installs new code.
// R16: Change with wrong old code decrements counter, keeps code, blocks on third.
// R17: Terminal sends change with first byte 00, length 10 hex, old then new.
// R18: All eight bytes are compared; counter and blocked update before the status.
package pcu_pkg;

   // ************************************************************
   // Sizes and command codes
   // ************************************************************
   localparam int          PCU_NREF       = 32;
   localparam logic [7:0]  PCU_INS_CHECK  = 8'h20;
   localparam logic [7:0]  PCU_INS_CHANGE = 8'h24;
   localparam logic [7:0]  PCU_P1_NONE    = 8'h00;
   localparam logic [7:0]  PCU_LC_EMPTY   = 8'h00;
   localparam logic [7:0]  PCU_LC_CHECK   = 8'h08;
   localparam logic [7:0]  PCU_LC_CHANGE  = 8'h10;
   localparam logic [1:0]  PCU_TRIES_INIT = 2'h3;
   localparam logic [63:0] PCU_CODE_RESET = 64'hffffffffffffffff;

   // ************************************************************
   // Status words
   // ************************************************************
   localparam logic [15:0] PCU_SW_OK       = 16'h9000;
   localparam logic [15:0] PCU_SW_TRIES    = 16'h63c0;
   localparam logic [15:0] PCU_SW_BLOCKED  = 16'h6983;
   localparam logic [15:0] PCU_SW_DISABLED = 16'h6984;
   localparam logic [15:0] PCU_SW_BAD_P1P2 = 16'h6b00;
   localparam logic [15:0] PCU_SW_BAD_LEN  = 16'h6700;
   localparam logic [15:0] PCU_SW_BAD_INS  = 16'h6d00;

   // ************************************************************
   // Register map (byte addresses) and fields
   // ************************************************************
   localparam logic [11:0] PCU_A_CTRL    = 12'h000;
   localparam logic [11:0] PCU_A_CMD     = 12'h004;
   localparam logic [11:0] PCU_A_DATA0   = 12'h008;
   localparam logic [11:0] PCU_A_DATA1   = 12'h00c;
   localparam logic [11:0] PCU_A_DATA2   = 12'h010;
   localparam logic [11:0] PCU_A_DATA3   = 12'h014;
   localparam logic [11:0] PCU_A_SW      = 12'h018;
   localparam logic [11:0] PCU_A_IRQ_ST  = 12'h01c;
   localparam logic [11:0] PCU_A_IRQ_MSK = 12'h020;
   localparam logic [11:0] PCU_A_REFSEL  = 12'h024;
   localparam logic [11:0] PCU_A_REFST   = 12'h028;
   localparam logic [11:0] PCU_A_DISABLE = 12'h02c;
   localparam logic [11:0] PCU_A_UNBLOCK = 12'h030;
   localparam int          PCU_CTRL_GO   = 0;
   localparam int          PCU_CTRL_CLRV = 1;
   localparam int          PCU_IRQ_DONE  = 0;
   localparam int          PCU_IRQ_FAIL  = 1;
   localparam int          PCU_IRQ_BLOCK = 2;
   localparam logic [2:0]  PCU_IRQ_RESET = 3'h0;

   // Command header as written by software
   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
   } pcu_cmd_type;

   // Decoded reference selector
   typedef struct packed {
      logic       valid;
      logic       specific;
      logic [4:0] num;
   } pcu_ref_type;

endpackage

// ==== pcu_cmp.sv ====
// Full-width comparator for an eight-byte code
`timescale 1ns/100ps
module pcu_cmp
   import pcu_pkg::*;
(
   // Operands
   input  wire logic [63:0] given,
   input  wire logic [63:0] stored,
   // Result
   output logic             match
);

   // Every byte is compared before the decision, no early exit on a mismatch
   wire [7:0] byte_eq;
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_byte
         assign byte_eq[i] = (given[8*i +: 8] == stored[8*i +: 8]); // [R18]
      end
   endgenerate
   assign match = &byte_eq;

endmodule

// ==== pcu_top.sv ====
// Code check and change unit with APB register access
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module pcu_top
   import pcu_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Access gate for the last selected file
   input  wire logic        acc_need,
   input  wire logic [6:0]  acc_ref,
   output logic             acc_grant,
   // Interrupt
   output logic             irq
);

   // ************************************************************
   // State of each code reference
   // ************************************************************
   // Held in plain flip-flops here; the counter and blocked bits stand for the
   // non-volatile copy, so they must be restored by the card shell after power-up.
   logic [63:0] code_mem [0:2*PCU_NREF-1];
   logic [1:0]  tries    [0:2*PCU_NREF-1];
   logic [2*PCU_NREF-1:0] blocked;
   logic [2*PCU_NREF-1:0] disabled;
   logic [2*PCU_NREF-1:0] verified;

   // ************************************************************
   // Software registers
   // ************************************************************
   pcu_cmd_type cmd;
   logic [31:0] data_w [0:3];
   logic [15:0] sw;
   logic [2:0]  irq_st;
   logic [2:0]  irq_msk;
   logic [5:0]  refsel;
   logic        busy;

   typedef enum {PCU_IDLE, PCU_EXEC} pcu_state_type;
   pcu_state_type state;

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire        wr_en   = psel && penable && pwrite;
   wire        rd_en   = psel && penable && !pwrite;
   wire        a_ctrl  = (paddr == PCU_A_CTRL);
   wire        a_cmd   = (paddr == PCU_A_CMD);
   wire        a_d0    = (paddr == PCU_A_DATA0);
   wire        a_d1    = (paddr == PCU_A_DATA1);
   wire        a_d2    = (paddr == PCU_A_DATA2);
   wire        a_d3    = (paddr == PCU_A_DATA3);
   wire        a_sw    = (paddr == PCU_A_SW);
   wire        a_ist   = (paddr == PCU_A_IRQ_ST);
   wire        a_imsk  = (paddr == PCU_A_IRQ_MSK);
   wire        a_rsel  = (paddr == PCU_A_REFSEL);
   wire        a_rst   = (paddr == PCU_A_REFST);
   wire        a_dis   = (paddr == PCU_A_DISABLE);
   wire        a_unb   = (paddr == PCU_A_UNBLOCK);
   wire        mapped  = a_ctrl | a_cmd | a_d0 | a_d1 | a_d2 | a_d3 | a_sw | a_ist |
                         a_imsk | a_rsel | a_rst | a_dis | a_unb;
   wire        go      = wr_en && a_ctrl && pwdata[PCU_CTRL_GO] && !busy;
   wire        clr_ver = wr_en && a_ctrl && pwdata[PCU_CTRL_CLRV];

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ************************************************************
   // Command decode
   // ************************************************************
   wire [5:0]  idx      = {cmd.p2[7], cmd.p2[4:0]};
   wire        p2_ok    = (cmd.p2[6:5] == 2'h0) && (cmd.p2[4:0] != 5'h00); // [R12]
   wire        is_chk   = (cmd.ins == PCU_INS_CHECK);
   wire        is_chg   = (cmd.ins == PCU_INS_CHANGE);
   wire        p1_ok    = (cmd.p1 == PCU_P1_NONE);
   wire        len_ok   = is_chk ? (cmd.lc == PCU_LC_EMPTY || cmd.lc == PCU_LC_CHECK)
                                 : (cmd.lc == PCU_LC_CHANGE);
   wire        query    = is_chk && (cmd.lc == PCU_LC_EMPTY); // [R09]
   wire [63:0] old_code = {data_w[0], data_w[1]};  // Bytes 1 to 8, byte 1 most significant
   wire [63:0] new_code = {data_w[2], data_w[3]};  // Bytes 9 to 16
   wire        is_blk   = blocked[idx];
   wire        is_dis   = disabled[idx];
   wire [1:0]  cur_try  = tries[idx];
   wire [1:0]  dec_try  = cur_try - 2'h1;
   wire        match;

   pcu_cmp u_cmp
   (
      .given  (old_code),
      .stored (code_mem[idx]),
      .match  (match)
   );

   // ************************************************************
   // Outcome of the command held in the registers
   // ************************************************************
   logic [15:0] next_sw;
   logic        do_ok;
   logic        do_fail;
   logic        do_inst;
   always_comb
   begin
      next_sw = PCU_SW_OK;
      do_ok   = 1'b0;
      do_fail = 1'b0;
      do_inst = 1'b0;
      if (!is_chk && !is_chg)
         next_sw = PCU_SW_BAD_INS;
      else if (!p1_ok || !p2_ok)
         next_sw = PCU_SW_BAD_P1P2;
      else if (!len_ok)
         next_sw = PCU_SW_BAD_LEN;
      else if (query)
         next_sw = PCU_SW_TRIES | {14'h0, cur_try}; // [R09]
      else if (is_blk)
         next_sw = PCU_SW_BLOCKED; // [R07] [R02] [R14]
      else if (is_dis)
         next_sw = PCU_SW_DISABLED; // [R02] [R14]
      else if (match)
      begin
         do_ok   = 1'b1; // [R04] [R15]
         do_inst = is_chg; // [R13]
      end
      else
      begin
         do_fail = 1'b1; // [R05] [R16]
         next_sw = PCU_SW_TRIES | {14'h0, dec_try}; // [R10] [R06]
      end
   end

   // ************************************************************
   // Sequencer: one cycle to latch, one to execute
   // ************************************************************
   // The counter, blocked bit and status word all update on the same edge, so
   // software never sees a status word ahead of the stored state.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state <= PCU_IDLE;
      else
         unique case (state)
            PCU_IDLE: if (go) state <= PCU_EXEC;
            PCU_EXEC: state <= PCU_IDLE;
         endcase
   end
   assign busy = (state == PCU_EXEC);
   wire exec = busy;

   // Per-reference state, shared by every logical channel
   genvar r;
   generate
      for (r = 0; r < 2*PCU_NREF; r++)
      begin : g_ref
         wire sel  = exec && (idx == 6'(r));
         wire dis_w = wr_en && a_dis && (pwdata[5:0] == 6'(r));
         wire unb_w = wr_en && a_unb && (pwdata[5:0] == 6'(r));
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               tries[r]    <= PCU_TRIES_INIT;
               blocked[r]  <= 1'b0;
               disabled[r] <= 1'b0;
               verified[r] <= 1'b0;
               code_mem[r] <= PCU_CODE_RESET;
            end
            else if (sel && do_ok)
            begin
               tries[r]    <= PCU_TRIES_INIT; // [R04] [R15]
               verified[r] <= 1'b1; // [R01]
               if (do_inst)
                  code_mem[r] <= new_code; // [R13] [R15]
            end
            else if (sel && do_fail)
            begin
               tries[r]    <= dec_try; // [R05] [R16]
               verified[r] <= 1'b0;
               if (dec_try == 2'h0)
                  blocked[r] <= 1'b1; // [R06] [R16] [R18]
            end
            else if (unb_w)
            begin
               tries[r]   <= PCU_TRIES_INIT;
               blocked[r] <= 1'b0; // [R08]
            end
            else if (dis_w)
               disabled[r] <= pwdata[8];
            else if (clr_ver)
               verified[r] <= 1'b0;
         end
      end
   endgenerate

   // ************************************************************
   // Access gate for a guarded function
   // ************************************************************
   wire [5:0] gidx = {acc_ref[6], acc_ref[4:0]};
   assign acc_grant = !acc_need || disabled[gidx] ||
                      (verified[gidx] && !blocked[gidx]); // [R03] [R08]

   // ************************************************************
   // Register writes
   // ************************************************************
   wire [2:0] ev = {exec && do_fail && dec_try == 2'h0, exec && do_fail, exec};
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd     <= '0;
         data_w  <= '{default: 32'h0};
         sw      <= PCU_SW_OK;
         irq_st  <= PCU_IRQ_RESET;
         irq_msk <= PCU_IRQ_RESET;
         refsel  <= 6'h00;
      end
      else
      begin
         if (wr_en && a_cmd && !busy) cmd <= pwdata;
         if (wr_en && a_d0 && !busy) data_w[0] <= pwdata;
         if (wr_en && a_d1 && !busy) data_w[1] <= pwdata;
         if (wr_en && a_d2 && !busy) data_w[2] <= pwdata;
         if (wr_en && a_d3 && !busy) data_w[3] <= pwdata;
         if (wr_en && a_imsk) irq_msk <= pwdata[2:0];
         if (wr_en && a_rsel) refsel <= pwdata[5:0];
         if (exec) sw <= next_sw; // [R18]
         // Set wins over a write-one clear in the same cycle
         irq_st <= (irq_st & ~((wr_en && a_ist) ? pwdata[2:0] : 3'h0)) | ev;
      end
   end

   assign irq = |(irq_st & irq_msk);

   // ************************************************************
   // Read mux
   // ************************************************************
   wire [31:0] refst = {24'h0, 1'b0, verified[refsel], disabled[refsel], blocked[refsel],
                        2'h0, tries[refsel]};
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
         prdata <= (paddr == PCU_A_CTRL)    ? {31'h0, busy} :
                   (paddr == PCU_A_CMD)     ? cmd :
                   (paddr == PCU_A_SW)      ? {16'h0, sw} :
                   (paddr == PCU_A_IRQ_ST)  ? {29'h0, irq_st} :
                   (paddr == PCU_A_IRQ_MSK) ? {29'h0, irq_msk} :
                   (paddr == PCU_A_REFSEL)  ? {26'h0, refsel} :
                   (paddr == PCU_A_REFST)   ? refst : 32'h0;
   end

endmodule

// ==== pcu_checker.sv ====
// Port assertions for the code check and change unit
`timescale 1ns/100ps
module pcu_checker
   import pcu_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Gate and interrupt
   input wire logic        acc_need,
   input wire logic [6:0]  acc_ref,
   input wire logic        acc_grant,
   input wire logic        irq
);
   // ****
   // State only moves after a write, or a command one launched
   // ****
   wire logic wr = psel & penable & pwrite;
   wire logic rd = psel & penable & !pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_grant_free: assert property (!acc_need |-> acc_grant)
      else $error("grant withheld");
   a_grant_rise: assert property (
      acc_need && $past(acc_need) && $stable(acc_ref) && $rose(acc_grant)
      |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3)) else $error("grant rose alone");
   a_grant_fall: assert property (
      acc_need && $past(acc_need) && $stable(acc_ref) && $fell(acc_grant)
      |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3)) else $error("grant fell alone");
   a_irq_rise: assert property ($rose(irq) |-> $past(wr, 1) || $past(wr, 2))
      else $error("irq rose alone");
   a_irq_fall: assert property ($fell(irq) |-> $past(wr))
      else $error("irq fell alone");
   a_sw_class: assert property (
      rd && paddr == PCU_A_SW |-> prdata[15:8] inside {8'h90, 8'h63, 8'h69, 8'h67, 8'h6b, 8'h6d})
      else $error("bad status class");
   a_block_zero: assert property (
      rd && paddr == PCU_A_REFST |-> prdata[4] == (prdata[1:0] == 2'h0))
      else $error("blocked and tries disagree");
   a_err_unmapped: assert property (psel && penable && paddr > PCU_A_UNBLOCK |-> pslverr)
      else $error("unmapped not refused");
endmodule

// ==== pcu_term.sv ====
// Terminal model issuing commands over APB
`timescale 1ns/100ps
module pcu_term
   import pcu_pkg::*;
(
   // Clock and pacing
   input wire logic        clk,
   input wire logic        slow,
   // APB master
   output logic            psel,
   output logic            penable,
   output logic            pwrite,
   output logic [11:0]     paddr,
   output logic [31:0]     pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready
);
   // ****
   // Bus cycles
   // ****
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer from just after an edge; slow terminals idle longer
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // No stale data left on a released bus
      repeat (slow ? 3 : 1)
         @(posedge clk);
   endtask

   // Header, both codes, launch, poll busy, fetch status
   task automatic cmd(input logic [31:0] hdr, input logic [127:0] dat, output logic [15:0] sw);
      logic [31:0] q;
      int          n;
      xfer(1'b1, PCU_A_CMD, hdr, q);
      for (n = 0; n < 4; n++)
         xfer(1'b1, PCU_A_DATA0 + 12'(4 * n), dat[127 - 32 * n -: 32], q);
      xfer(1'b1, PCU_A_CTRL, 32'h1, q);
      q = 32'h1;
      for (n = 0; n < 50 && q[0] !== 1'b0; n++)
         xfer(1'b0, PCU_A_CTRL, 32'h0, q);
      xfer(1'b0, PCU_A_SW, 32'h0, q);
      sw = q[15:0];
   endtask
endmodule

// ==== pcu_top_tb.sv ====
// Self-checking bench for the code check and change unit
`timescale 1ns/100ps
module pcu_top_tb
   import pcu_pkg::*;
;
   logic        clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, acc_need = 1'b1, msk = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, acc_grant, irq;
   logic [6:0]  acc_ref = 7'h01;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, t, seed = 32'd94;
   logic [4:0]  cur = 5'h1;
   logic [63:0] k;
   logic [1:0]  tries [64] = '{default: PCU_TRIES_INIT};
   logic [63:0] code [64] = '{default: PCU_CODE_RESET};
   logic        blk [64] = '{default: 1'b0}, ver [64] = '{default: 1'b0};
   logic        dis [64] = '{default: 1'b0};
   logic [31:0] bad [6] = '{32'h20010108, 32'h20000008, 32'h20002108, 32'h20000104,
                            32'h24000108, 32'h22000108};
   int          num_errors = 0, total_checks = 0, i;

   pcu_top DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                .pslverr, .acc_need, .acc_ref, .acc_grant, .irq);
   pcu_term term (.clk, .slow, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
   always #25 clk = ~clk;

   // ****
   // Helpers and reference model
   // ****
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // One flipped byte anywhere must still fail
   function automatic logic [63:0] wrong(input logic [63:0] c);
      logic [31:0] r;
      r = xs();
      return c ^ (64'hff << (8 * r[2:0]));
   endfunction
   function automatic logic [31:0] hd(input logic [7:0] ins, lc);
      return {ins, PCU_P1_NONE, 3'h0, cur, lc};
   endfunction
   function automatic logic [15:0] predict(input pcu_cmd_type c, input logic [63:0] o, n);
      logic [5:0] r;
      r = {c.p2[7], c.p2[4:0]};
      if (c.ins != PCU_INS_CHECK && c.ins != PCU_INS_CHANGE)
         return PCU_SW_BAD_INS;
      if (c.p1 != PCU_P1_NONE || c.p2[6:5] != 2'h0 || r[4:0] == 5'h0)
         return PCU_SW_BAD_P1P2;
      if (c.ins == PCU_INS_CHANGE ? c.lc != PCU_LC_CHANGE
                                  : c.lc != PCU_LC_CHECK && c.lc != PCU_LC_EMPTY)
         return PCU_SW_BAD_LEN;
      if (c.ins == PCU_INS_CHECK && c.lc == PCU_LC_EMPTY)
         return PCU_SW_TRIES | 16'(tries[r]);
      if (blk[r])
         return PCU_SW_BLOCKED;
      if (dis[r])
         return PCU_SW_DISABLED;
      ver[r] = o == code[r];
      if (ver[r])
      begin
         tries[r] = PCU_TRIES_INIT;
         code[r] = c.ins == PCU_INS_CHANGE ? n : code[r];
         return PCU_SW_OK;
      end
      tries[r] = tries[r] - 2'h1;
      blk[r] = tries[r] == 2'h0;
      return PCU_SW_TRIES | 16'(tries[r]);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Run a command, then compare status, gate and interrupt
   task automatic run(input logic [31:0] h, input logic [63:0] o, n);
      logic [15:0] sw, e;
      logic [5:0]  g;
      acc_ref <= {h[15], 1'b0, h[12:8]};
      g = {h[15], h[12:8]};
      e = predict(h, o, n);
      term.cmd(h, {o, n}, sw);
      check(32'(sw), 32'(e));
      check(32'(acc_grant), 32'(!acc_need | dis[g] | ver[g] & !blk[g]));
      check(32'(irq), 32'(msk));
      term.xfer(1'b1, PCU_A_IRQ_ST, 32'h7, q);
      check(32'(irq), 32'h0);
   endtask
   task automatic unblock();
      term.xfer(1'b1, PCU_A_UNBLOCK, {27'h0, cur}, q);
      tries[cur] = PCU_TRIES_INIT;
      blk[cur] = 1'b0;
   endtask

   // Hang guard, far beyond a run of a few thousand cycles
   initial
   begin
      #(50 * 40000);
      num_errors++;
      conclude();
   end

   // ****
   // Main sequence
   // ****
   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check(32'(acc_grant), 32'h0);
      term.xfer(1'b1, PCU_A_REFSEL, 32'h1, q);
      term.xfer(1'b0, PCU_A_REFST, 32'h0, q);
      check(q, 32'h3);
      term.xfer(1'b1, PCU_A_IRQ_MSK, 32'h7, q);
      run(hd(PCU_INS_CHECK, PCU_LC_EMPTY), 64'h0, 64'h0);
      run(hd(PCU_INS_CHECK, PCU_LC_CHECK), wrong(PCU_CODE_RESET), 64'h0);
      run(hd(PCU_INS_CHECK, PCU_LC_CHECK), PCU_CODE_RESET, 64'h0);
      k = {xs(), xs()};
      run(hd(PCU_INS_CHANGE, PCU_LC_CHANGE), PCU_CODE_RESET, k);
      run(hd(PCU_INS_CHECK, PCU_LC_CHECK), PCU_CODE_RESET, 64'h0);
      run(hd(PCU_INS_CHANGE, PCU_LC_CHANGE), wrong(k), 64'h0);
      // Misses until blocked, then correct codes are refused
      for (i = 0; i < 3; i++)
         run(hd(PCU_INS_CHECK, PCU_LC_CHECK), wrong(k), 64'h0);
      run(hd(PCU_INS_CHECK, PCU_LC_CHECK), k, 64'h0);
      run(hd(PCU_INS_CHANGE, PCU_LC_CHANGE), k, 64'h0);
      run(hd(PCU_INS_CHECK, PCU_LC_EMPTY), k, 64'h0);
      term.xfer(1'b0, PCU_A_REFST, 32'h0, q);
      check(q, 32'h10);
      unblock();
      term.xfer(1'b1, PCU_A_DISABLE, {23'h0, 1'b1, 3'h0, cur}, q);
      dis[cur] = 1'b1;
      run(hd(PCU_INS_CHECK, PCU_LC_CHECK), k, 64'h0);
      term.xfer(1'b1, PCU_A_DISABLE, {27'h0, cur}, q);
      dis[cur] = 1'b0;
      // Application-specific reference 1 keeps its own counter apart from global 1
      run({PCU_INS_CHECK, PCU_P1_NONE, 8'h81, PCU_LC_CHECK}, wrong(PCU_CODE_RESET), 64'h0);
      run(hd(PCU_INS_CHECK, PCU_LC_EMPTY), k, 64'h0);
      foreach (bad[i])
         run(bad[i], k, 64'h0);
      term.xfer(1'b0, 12'h040, 32'h0, q);
      check(q, 32'h0);
      term.xfer(1'b1, PCU_A_IRQ_MSK, 32'h0, q);
      msk = 1'b0;
      run(hd(PCU_INS_CHECK, PCU_LC_EMPTY), k, 64'h0);
      term.xfer(1'b1, PCU_A_IRQ_MSK, 32'h7, q);
      msk = 1'b1;
      // Random mix over four references
      repeat (40)
      begin
         t = xs();
         cur = 5'(t[1:0]) + 5'h1;
         slow <= t[2];
         acc_need <= t[8];
         if (t[5:4] == 2'h0 && blk[cur])
            unblock();
         run(hd(t[6] ? PCU_INS_CHANGE : PCU_INS_CHECK,
                t[6] ? PCU_LC_CHANGE : t[7] ? PCU_LC_CHECK : PCU_LC_EMPTY),
             t[3] ? code[cur] : wrong(code[cur]), {xs(), xs()});
      end
      conclude();
   end
endmodule

bind pcu_top pcu_checker u_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
                                .prdata, .pready, .pslverr, .acc_need, .acc_ref, .acc_grant, .irq);
